/* src/fsr_cfg.svh */
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

// Clock and timing
`define FSR_CLK_HZ 10000000
`define FSR_OC_TIME_MS 48
`define FSR_OC_CYCLES ((`FSR_OC_TIME_MS * `FSR_CLK_HZ + 999) / 1000)
`define FSR_OC_TW 20

// Bus address, value arbitrary
`define FSR_DEV_ADDR 7'h2A

// Control byte layout
`define FSR_CTRL_SEL_HI 7
`define FSR_CTRL_SEL_LO 6
`define FSR_CTRL_SEL_MAIN 2'h0
`define FSR_CTRL_SEL_AUX 2'h2
`define FSR_CTRL_ON_BIT 5
`define FSR_CTRL_CABLE_BIT 2

// Primary status bit positions
`define FSR_ST1_OFF_BIT 0
`define FSR_ST1_OC_BIT 2
`define FSR_ST1_PB_BIT 4
`define FSR_ST1_TH_BIT 6
`define FSR_ST1_UV_BIT 7

// Secondary status bit positions
`define FSR_ST2_CABLE_BIT 0
`define FSR_ST2_TONE_BIT 2

// Bit counter values
`define FSR_CNT_BYTE_END 4'h8
`define FSR_CNT_LAST_DATA 4'h7

`endif

/* src/fsr_pkg.sv */
package fsr_pkg;

  typedef enum logic [2:0] {
    FSR_IDLE = 3'b000,
    FSR_ADDR = 3'b001,
    FSR_WRITE = 3'b010,
    FSR_READ = 3'b011,
    FSR_IGNORE = 3'b100
  } fsr_bus_e;

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [6:0] shift;
  } fsr_fe_s;

  typedef struct packed {
    fsr_bus_e st;
    logic rw;
    logic rd_sel;
    logic wrote;
    logic [7:0] tx;
    logic sda_oe;
    logic sda_out;
    logic irq;
    logic on_ctrl;
    logic cable_ctrl;
    logic fault_off;
    logic out_en;
    logic off_flag;
    logic oc_flag;
    logic th_flag;
    logic uv_flag;
    logic pb_flag;
    logic tone_flag;
    logic cable_flag;
    logic [19:0] oc_timer;
  } fsr_core_s;

endpackage : fsr_pkg

/* src/fsr_bit_if.sv */
`timescale 1ns/10ps
interface fsr_bit_if;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic ninth;
  logic byte_rx;
  logic sda;
  logic [3:0] cnt;
  logic [7:0] rx_byte;

  modport fe (
    output start, stop, rise, fall, ninth, byte_rx, sda, cnt, rx_byte
  );
  modport core (
    input start, stop, rise, fall, ninth, byte_rx, sda, cnt, rx_byte
  );
endinterface : fsr_bit_if

/* src/fsr_bit_front.sv */
`timescale 1ns/10ps
`include "fsr_cfg.svh"
module fsr_bit_front (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  fsr_bit_if.fe bus
);

  fsr_pkg::fsr_fe_s s;
  fsr_pkg::fsr_fe_s next_s;

  always_comb begin
    bus.rise = i_scl & ~s.scl_q;
    bus.fall = ~i_scl & s.scl_q;
    bus.start = i_scl & s.scl_q & s.sda_q & ~i_sda;
    bus.stop = i_scl & s.scl_q & ~s.sda_q & i_sda;
    bus.sda = i_sda;
    bus.cnt = s.cnt;
    bus.rx_byte = {s.shift, i_sda};
    bus.byte_rx = bus.rise & (s.cnt == `FSR_CNT_LAST_DATA);
    bus.ninth = bus.rise & (s.cnt == `FSR_CNT_BYTE_END);
    next_s = s;
    next_s.scl_q = i_scl;
    next_s.sda_q = i_sda;
    if (bus.start || bus.stop) begin
      next_s.cnt = 4'h0;
    end else if (bus.rise) begin
      next_s.shift = {s.shift[5:0], i_sda};
      // Count wraps after the acknowledge clock
      next_s.cnt = bus.ninth ? 4'h0 : s.cnt + 4'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '{scl_q: 1'b1, sda_q: 1'b1, cnt: 4'h0, shift: 7'h00};
    end else begin
      s <= next_s;
    end
  end

endmodule : fsr_bit_front

/* src/fsr_top.sv */
`timescale 1ns/10ps
`include "fsr_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
module fsr_top #(
  parameter logic [6:0] DEV_ADDR = `FSR_DEV_ADDR,
  parameter int OC_CYCLES = `FSR_OC_CYCLES,
  parameter int OC_TW = `FSR_OC_TW
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_overcurrent,
  input wire logic i_over_temp,
  input wire logic i_supply_low,
  input wire logic i_out_below_85,
  input wire logic i_out_within_90,
  input wire logic i_out_above_21,
  input wire logic i_out_below_1995,
  input wire logic i_tone_present,
  output logic o_irq,
  output logic o_output_on,
  output logic o_cable_test
);

  localparam logic [OC_TW-1:0] OC_LAST = OC_TW'(OC_CYCLES - 1);
  localparam logic [OC_TW-1:0] OC_FULL = OC_TW'(OC_CYCLES);

  fsr_bit_if bus ();
  fsr_pkg::fsr_core_s s;
  fsr_pkg::fsr_core_s next_s;
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic oc_trip;
  logic ninth_rd;
  logic ack_evt;
  logic new_fault;

  fsr_bit_front u_front (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .bus(bus.fe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status byte images
  always_comb begin
    stat1 = 8'h00;
    stat1[`FSR_ST1_OFF_BIT] = s.off_flag;
    stat1[`FSR_ST1_OC_BIT] = s.oc_flag;
    stat1[`FSR_ST1_PB_BIT] = s.pb_flag;
    stat1[`FSR_ST1_TH_BIT] = s.th_flag;
    stat1[`FSR_ST1_UV_BIT] = s.uv_flag;
    stat2 = 8'h00;
    stat2[`FSR_ST2_CABLE_BIT] = s.cable_flag;
    stat2[`FSR_ST2_TONE_BIT] = s.tone_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    ack_evt = 1'b0;
    ninth_rd = bus.ninth && (s.st == fsr_pkg::FSR_READ);

    // Overcurrent persistence timer, saturates so it trips once
    oc_trip = 1'b0;
    if (!i_overcurrent) begin
      next_s.oc_timer = '0;
    end else if (s.oc_timer != OC_FULL) begin
      next_s.oc_timer = s.oc_timer + OC_TW'(1);
      oc_trip = (s.oc_timer == OC_LAST);
    end

    // Bus sequencing
    if (bus.start) begin
      next_s.st = fsr_pkg::FSR_ADDR;
      next_s.rd_sel = 1'b0;
      next_s.sda_oe = 1'b0;
    end else if (bus.stop) begin
      next_s.st = fsr_pkg::FSR_IDLE;
      next_s.sda_oe = 1'b0;
      next_s.wrote = 1'b0;
    end else begin
      if (bus.byte_rx) begin
        case (s.st)
          fsr_pkg::FSR_ADDR: begin
            next_s.rw = bus.rx_byte[0];
            if (bus.rx_byte[7:1] != DEV_ADDR) begin
              next_s.st = fsr_pkg::FSR_IGNORE;
            end
          end
          fsr_pkg::FSR_WRITE: begin
            next_s.wrote = 1'b1;
            case (bus.rx_byte[`FSR_CTRL_SEL_HI:`FSR_CTRL_SEL_LO])
              `FSR_CTRL_SEL_MAIN: begin
                next_s.on_ctrl = bus.rx_byte[`FSR_CTRL_ON_BIT];
                if (bus.rx_byte[`FSR_CTRL_ON_BIT]) begin
                  next_s.fault_off = 1'b0;
                end
              end
              `FSR_CTRL_SEL_AUX: begin
                next_s.cable_ctrl = bus.rx_byte[`FSR_CTRL_CABLE_BIT];
              end
              default: begin
              end
            endcase
          end
          default: begin
          end
        endcase
      end
      if (bus.ninth) begin
        if (s.st == fsr_pkg::FSR_ADDR) begin
          next_s.st = s.rw ? fsr_pkg::FSR_READ : fsr_pkg::FSR_WRITE;
        end else if (ninth_rd) begin
          next_s.rd_sel = ~s.rd_sel;
          // Master not acknowledging ends the read
          if (bus.sda) begin
            next_s.st = fsr_pkg::FSR_IGNORE;
          end
        end
      end
      // Data changes only while the clock is low
      if (bus.fall) begin
        if (bus.cnt == `FSR_CNT_BYTE_END) begin
          next_s.sda_oe = (s.st == fsr_pkg::FSR_ADDR) ||
                          (s.st == fsr_pkg::FSR_WRITE);
          ack_evt = (s.st == fsr_pkg::FSR_ADDR);
        end else if (s.st != fsr_pkg::FSR_READ) begin
          next_s.sda_oe = 1'b0;
        end else if (bus.cnt == 4'h0) begin
          next_s.tx = s.rd_sel ? stat2 : stat1;
          next_s.sda_oe = s.rd_sel ? ~stat2[7] : ~stat1[7];
        end else begin
          next_s.sda_oe = ~s.tx[3'(`FSR_CNT_LAST_DATA - bus.cnt)];
        end
      end
    end

    // Latched faults: thermal and undervoltage resampled, overcurrent cleared on the ninth read clock, set wins
    if (ninth_rd) begin
      next_s.oc_flag = 1'b0;
      next_s.th_flag = i_over_temp;
      next_s.uv_flag = i_supply_low;
    end
    new_fault = (oc_trip & ~s.oc_flag) | (i_over_temp & ~s.th_flag) |
                (i_supply_low & ~s.uv_flag);
    next_s.oc_flag = next_s.oc_flag | oc_trip;
    next_s.th_flag = next_s.th_flag | i_over_temp;
    next_s.uv_flag = next_s.uv_flag | i_supply_low;
    if (oc_trip || i_over_temp || i_supply_low) begin
      next_s.fault_off = 1'b1;
    end

    // Request drops on address ack; a new fault in that cycle keeps it
    if (ack_evt) begin
      next_s.irq = 1'b0;
    end
    if (new_fault) begin
      next_s.irq = 1'b1;
    end

    next_s.out_en = next_s.on_ctrl & ~next_s.fault_off;

    // Off flag never touches the request line
    if (!next_s.out_en) begin
      next_s.off_flag = 1'b1;
    end else if (bus.stop && s.wrote) begin
      next_s.off_flag = 1'b0;
    end

    // Self-clearing flags follow their conditions
    if (!s.out_en || i_out_below_85) begin
      next_s.pb_flag = 1'b1;
    end else if (i_out_within_90) begin
      next_s.pb_flag = 1'b0;
    end
    if (!s.cable_ctrl) begin
      next_s.cable_flag = 1'b0;
    end else if (i_out_above_21) begin
      next_s.cable_flag = 1'b1;
    end else if (i_out_below_1995) begin
      next_s.cable_flag = 1'b0;
    end
    next_s.tone_flag = i_tone_present;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; all flags zero only when healthy and enabled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.st <= fsr_pkg::FSR_IDLE;
      s.irq <= 1'b1;
      s.uv_flag <= 1'b1;
      s.off_flag <= 1'b1;
      s.pb_flag <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_sda = s.sda_out;
  assign o_sda_oe = s.sda_oe;
  assign o_irq = s.irq;
  assign o_output_on = s.out_en;
  assign o_cable_test = s.cable_ctrl;

endmodule : fsr_top

/* dv/fsr_top_properties.sv */
`timescale 1ns/10ps
module fsr_top_props #(
  parameter int OC_CYCLES = 20
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_overcurrent,
  input wire logic i_over_temp,
  input wire logic i_supply_low,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_irq,
  input wire logic o_output_on
);
  logic [19:0] oc_run;
  logic any_f;
  assign any_f = i_overcurrent | i_over_temp | i_supply_low;
  // Saturates so a stuck comparator never wraps back into range
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      oc_run <= 20'h00000;
    end else if (!i_overcurrent) begin
      oc_run <= 20'h00000;
    end else if (oc_run != 20'hFFFFF) begin
      oc_run <= oc_run + 20'h00001;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  //////////////////////
  irq_drop_a: assert property ($fell(o_irq) |-> $rose(o_sda_oe))
    else $error("irq released without address ack");
  irq_cause_a: assert property (
    $rose(o_irq) |-> $past(any_f) || $past(any_f, 2))
    else $error("irq raised without a fault");
  temp_lock_a: assert property (i_over_temp [*2] |=> !o_output_on)
    else $error("output on during overtemperature");
  supply_lock_a: assert property (i_supply_low |-> ##2 !o_output_on)
    else $error("output on after undervoltage");
  oc_lock_a: assert property (
    oc_run > 20'(OC_CYCLES + 3) |-> !o_output_on)
    else $error("output on after long overcurrent");
  drive_phase_a: assert property (
    $changed(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("data line moved while clock high");
  on_clean_a: assert property (
    $rose(o_output_on) |-> !$past(i_over_temp) && !$past(i_supply_low))
    else $error("output enabled under a fault");
  line_low_a: assert property (o_sda_oe |-> o_sda == 1'b0)
    else $error("data line driven high");
endmodule : fsr_top_props

/* dv/fsr_master.sv */
`timescale 1ns/10ps
module fsr_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda,
  output logic o_got,
  output logic [7:0] o_rx
);
  initial begin
    {o_scl, o_sda, o_got} = 3'h6;
    o_rx = 8'h00;
  end
  // Changes land a fixed delay after an edge, never on it
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
    #5;
  endtask : tk
  // Three cycles a phase, above the two the front end needs
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    tk(3);
    o_scl = 1'b1;
    tk(3);
    r = i_sda;
    o_scl = 1'b0;
    tk(1);
  endtask : bitx
  task automatic start;
    o_sda = 1'b1;
    tk(3);
    o_scl = 1'b1;
    tk(3);
    o_sda = 1'b0;
    tk(3);
    o_scl = 1'b0;
    tk(3);
  endtask : start
  task automatic stop;
    o_sda = 1'b0;
    tk(3);
    o_scl = 1'b1;
    tk(3);
    o_sda = 1'b1;
    tk(3);
  endtask : stop
  task automatic wr(input logic [7:0] d, output logic a);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(1'b1, a);
  endtask : wr
  task automatic rd(input logic nak);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(1'b1, o_rx[i]);
    bitx(nak, a);
    o_got = 1'b1;
    tk(1);
    o_got = 1'b0;
  endtask : rd
endmodule : fsr_master

/* dv/tb_fault_status_readback.sv */
`timescale 1ns/10ps
`include "fsr_cfg.svh"
module tb_fault_status_readback;
  localparam int OC = 20;
  logic i_clk, i_rst, scl, msda, oe, dsda, irq, on, ct, got;
  logic oc, ot, sl, b85, w90, a21, b19, tone;
  logic [7:0] rx;
  logic [31:0] rnd = 32'h0000D2DB;
  logic [7:0] q[$];
  int errors = 0;
  int samples_checked = 0;
  // Pull-up wire: either party only ever pulls low
  wire sda = msda && !(oe && !dsda);
  fsr_top #(.OC_CYCLES(OC)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_scl(scl), .i_sda(sda), .o_sda(dsda), .o_sda_oe(oe),
    .i_overcurrent(oc), .i_over_temp(ot), .i_supply_low(sl),
    .i_out_below_85(b85), .i_out_within_90(w90), .i_out_above_21(a21),
    .i_out_below_1995(b19), .i_tone_present(tone), .o_irq(irq),
    .o_output_on(on), .o_cable_test(ct));
  fsr_master m_u (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(msda),
    .o_got(got), .o_rx(rx));
  //////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #5;
  endtask : step
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic rdb(input int n, input logic [7:0] a, b = 8'h00);
    logic ak;
    q.push_back(a);
    if (n > 1) q.push_back(b);
    m_u.start();
    m_u.wr({`FSR_DEV_ADDR, 1'b1}, ak);
    chk({7'h00, ak}, 8'h00);
    for (int i = 1; i <= n; i++) m_u.rd(i == n);
    m_u.stop();
  endtask : rdb
  task automatic wrc(input logic [7:0] d);
    logic ak;
    m_u.start();
    m_u.wr({`FSR_DEV_ADDR, 1'b0}, ak);
    chk({7'h00, ak}, 8'h00);
    m_u.wr(d, ak);
    chk({7'h00, ak}, 8'h00);
    m_u.stop();
  endtask : wrc
  always @(posedge i_clk) if (got === 1'b1) chk(rx, q.pop_front());
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    repeat (40000) @(posedge i_clk);
    errors++;
    close_out();
  end
  initial begin
    {oc, ot, sl, a21, tone, w90} = 6'h00;
    {i_rst, b85, b19} = 3'h7;
    step(3);
    i_rst = 1'b0;
    step(2);
    chk({7'h00, irq}, 8'h01);
    rdb(2, 8'h91, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rdb(1, 8'h11);
    {b85, w90} = 2'h1;
    wrc(8'h20);
    wrc(8'h84);
    chk({6'h00, ct, on}, 8'h03);
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      {tone, a21, b19} = {rnd[1:0], ~rnd[0]};
      step(3);
      rdb(2, 8'h00, {5'h00, rnd[1], 1'b0, rnd[0]});
    end
    ot = 1'b1;
    step(3);
    chk({6'h00, irq, on}, 8'h02);
    rdb(1, 8'h51);
    rdb(1, 8'h51);
    ot = 1'b0;
    rdb(1, 8'h51);
    rdb(1, 8'h11);
    wrc(8'h20);
    rdb(1, 8'h00);
    sl = 1'b1;
    step(3);
    sl = 1'b0;
    step(3);
    chk({6'h00, irq, on}, 8'h02);
    rdb(1, 8'h91);
    rdb(1, 8'h11);
    chk({7'h00, on}, 8'h00);
    wrc(8'h20);
    oc = 1'b1;
    step(OC - 2);
    oc = 1'b0;
    step(2);
    chk({6'h00, irq, on}, 8'h01);
    oc = 1'b1;
    step(OC + 4);
    chk({6'h00, irq, on}, 8'h02);
    rdb(1, 8'h15);
    rdb(1, 8'h11);
    oc = 1'b0;
    wrc(8'h20);
    wrc(8'h00);
    chk({6'h00, irq, on}, 8'h00);
    rdb(1, 8'h11);
    close_out();
  end
endmodule : tb_fault_status_readback
bind fsr_top fsr_top_props #(.OC_CYCLES(OC_CYCLES)) chk_u (.i_clk, .i_rst,
  .i_scl, .i_overcurrent, .i_over_temp, .i_supply_low, .o_sda, .o_sda_oe,
  .o_irq, .o_output_on);
